// [core/hsg_gpio_port.sv]
// four-pin gpio port with its onboard hotswap status logic
//
// Behaviour
// - output-enable clear ones make pins input-only
// - output-enable set ones make pins drive
// - zeros ignored; fields read last written value
// - reset: enables zero, all pins input-only
// - input field mirrors pin levels, read-only
// - bits 27:24 read as zero
// - output-data clear ones drive pin low
// - output-data set ones drive pin high
// - new data on pins one edge after the write edge
// - input-only pins are never driven
// - hotswap bits sit on fixed bridge pins
// - open handle starts the enum interrupt
// - low-active enum on extract or insert
// - stable supply then reset mezzanine slots
// - extraction, insertion, led and mask bits
`timescale 1ns/1ps
`include "hsg_map.svh"

module hsg_gpio_port #(
	parameter int PINS       = 4,
	parameter int SETTLE_CYC = `HSG_SETTLE_CYC
) (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              rst_b,
	// configuration access
	input  wire logic              cfg_wr,
	input  wire logic              cfg_rd,
	input  wire logic [7:0]        cfg_addr,
	input  wire logic [3:0]        cfg_be_b,
	input  wire logic [31:0]       cfg_wdata,
	output logic      [31:0]       cfg_rdata,
	output logic                   cfg_rvalid,
	// bridge gpio pins
	input  wire logic [PINS-1:0]   gpio_in,
	output logic      [PINS-1:0]   gpio_out,
	output logic      [PINS-1:0]   gpio_oe,
	// board hotswap signals
	input  wire logic              handle_open,
	input  wire logic              supply_good,
	output logic                   enum_b,
	output logic                   led_safe,
	output logic                   slot_rst_b
);

	// ==========================================
	// helpers

	// write-1-to-set / write-1-to-clear update of one nibble; set wins a tie
	function automatic hsg_pkg::hsg_nibble_t w1_update(input hsg_pkg::hsg_nibble_t cur,
		input hsg_pkg::hsg_nibble_t set_bits, input hsg_pkg::hsg_nibble_t clr_bits);
		w1_update = (cur & ~clr_bits) | set_bits;
	endfunction : w1_update

	// ==========================================
	// register state
	// the field copies only serve read-back; od_reg and oe_reg hold the live state
	hsg_pkg::hsg_nibble_t od_reg;          // output data
	hsg_pkg::hsg_nibble_t oe_reg;          // output enable
	hsg_pkg::hsg_nibble_t od_clr_reg;      // last written output-data clear field
	hsg_pkg::hsg_nibble_t od_set_reg;      // last written output-data set field
	hsg_pkg::hsg_nibble_t oe_clr_reg;      // last written output-enable clear field
	hsg_pkg::hsg_nibble_t oe_set_reg;      // last written output-enable set field
	hsg_pkg::hsg_nibble_t od_next;
	hsg_pkg::hsg_nibble_t oe_next;
	hsg_pkg::hsg_nibble_t in_reg;          // sampled pin levels
	hsg_pkg::hsg_nibble_t pin_meta_reg;    // first synchroniser stage
	hsg_pkg::hsg_nibble_t pin_sync_reg;    // second synchroniser stage
	hsg_pkg::hsg_nibble_t pin_level;
	logic [31:0]          rdata_reg;
	logic [31:0]          rdata_next;
	logic                 rvalid_reg;
	logic [PINS-1:0]      gpio_out_reg;
	logic [PINS-1:0]      gpio_oe_reg;

	// ==========================================
	// access decode

	// all three registers share one doubleword; an active-low lane picks each
	logic                 hit;
	logic                 wr_od;
	logic                 wr_oe;
	logic                 rd_hit;
	hsg_pkg::hsg_nibble_t wd_od_clr;
	hsg_pkg::hsg_nibble_t wd_od_set;
	hsg_pkg::hsg_nibble_t wd_oe_clr;
	hsg_pkg::hsg_nibble_t wd_oe_set;

	// the low two address bits are ignored; the active-low byte enables pick the lanes
	assign hit       = (cfg_addr[7:2] == 6'(`HSG_DWORD_ADDR >> 2));
	assign wr_od     = cfg_wr && hit && !cfg_be_b[`HSG_LANE_OUT_DATA];
	assign wr_oe     = cfg_wr && hit && !cfg_be_b[`HSG_LANE_OUT_EN];
	// the input lane has no write decode: that register is read-only
	assign rd_hit    = cfg_rd && hit;
	assign wd_od_clr = cfg_wdata[`HSG_OD_CLR_LSB +: 4];
	assign wd_od_set = cfg_wdata[`HSG_OD_SET_LSB +: 4];
	assign wd_oe_clr = cfg_wdata[`HSG_OE_CLR_LSB +: 4];
	assign wd_oe_set = cfg_wdata[`HSG_OE_SET_LSB +: 4];

	// ==========================================
	// next values of data and enable

	// zeros in a written field leave the bit alone
	assign od_next = wr_od ? w1_update(od_reg, wd_od_set, wd_od_clr) : od_reg;
	assign oe_next = wr_oe ? w1_update(oe_reg, wd_oe_set, wd_oe_clr) : oe_reg;

	// output data and enable registers
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			od_reg <= `HSG_RST_NIBBLE;
			oe_reg <= `HSG_RST_NIBBLE;
		end else begin
			od_reg <= od_next;
			oe_reg <= oe_next;
		end
	end

	// read-back copies of the last value written to each field
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			od_clr_reg <= `HSG_RST_NIBBLE;
			od_set_reg <= `HSG_RST_NIBBLE;
			oe_clr_reg <= `HSG_RST_NIBBLE;
			oe_set_reg <= `HSG_RST_NIBBLE;
		end else begin
			if (wr_od) begin
				od_clr_reg <= wd_od_clr;
				od_set_reg <= wd_od_set;
			end
			if (wr_oe) begin
				oe_clr_reg <= wd_oe_clr;
				oe_set_reg <= wd_oe_set;
			end
		end
	end

	// ==========================================
	// pin drive

	// pins follow the registers one edge after the write edge
	// masking data with the enable keeps input-only pins from ever carrying a one
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			gpio_out_reg <= '0;
			gpio_oe_reg  <= '0;
		end else begin
			gpio_out_reg <= od_reg[PINS-1:0] & oe_reg[PINS-1:0];
			gpio_oe_reg  <= oe_reg[PINS-1:0];
		end
	end

	assign gpio_out = gpio_out_reg;
	assign gpio_oe  = gpio_oe_reg;

	// ==========================================
	// onboard hotswap logic

	// handle switch and supply good come from outside; two flops each
	// only the second stage is read; the first may still be settling
	logic handle_meta_reg;
	logic handle_sync_reg;
	logic supply_meta_reg;
	logic supply_sync_reg;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			handle_meta_reg <= 1'b0;
			handle_sync_reg <= 1'b0;
			supply_meta_reg <= 1'b0;
			supply_sync_reg <= 1'b0;
		end else begin
			handle_meta_reg <= handle_open;
			handle_sync_reg <= handle_meta_reg;
			supply_meta_reg <= supply_good;
			supply_sync_reg <= supply_meta_reg;
		end
	end

	// board reads led and mask only where the bridge really drives the pin
	// a pin left as input or driven low reads as inactive on the board
	logic led_on_control;
	logic enum_mask_control;

	assign led_on_control    = gpio_oe_reg[`HSG_PIN_LED] & gpio_out_reg[`HSG_PIN_LED];
	assign enum_mask_control = gpio_oe_reg[`HSG_PIN_MASK] & gpio_out_reg[`HSG_PIN_MASK];

	// supply sequencing: slot reset held until supply stable for the settle time
	// a supply drop at any point returns to off and pulls slot reset low again
	hsg_pkg::hsg_pwr_t         pwr_reg;
	hsg_pkg::hsg_pwr_t         pwr_next;
	logic [$clog2(SETTLE_CYC+1)-1:0] settle_reg;
	logic [$clog2(SETTLE_CYC+1)-1:0] settle_next;
	logic                      settle_done;

	assign settle_done = (settle_reg == ($clog2(SETTLE_CYC+1))'(SETTLE_CYC - 1));

	always_comb begin
		pwr_next    = pwr_reg;
		settle_next = '0;
		unique case (pwr_reg)
			hsg_pkg::HSG_PWR_OFF: begin
				if (supply_sync_reg) begin
					pwr_next = hsg_pkg::HSG_PWR_SETTLE;
				end
			end
			hsg_pkg::HSG_PWR_SETTLE: begin
				settle_next = settle_reg + 1'b1;
				if (!supply_sync_reg) begin
					pwr_next = hsg_pkg::HSG_PWR_OFF;
				end else if (settle_done) begin
					pwr_next = hsg_pkg::HSG_PWR_ON;
				end
			end
			hsg_pkg::HSG_PWR_ON: begin
				if (!supply_sync_reg) begin
					pwr_next = hsg_pkg::HSG_PWR_OFF;
				end
			end
			// the fourth code is never entered; fall back to the off state
			default: begin
				pwr_next = hsg_pkg::HSG_PWR_OFF;
			end
		endcase
	end

	// sequencer state and settle counter
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			pwr_reg    <= hsg_pkg::HSG_PWR_OFF;
			settle_reg <= '0;
		end else begin
			pwr_reg    <= pwr_next;
			settle_reg <= settle_next;
		end
	end

	// extraction follows the handle; insertion set by power-up, cleared by the mask or an open handle
	// power-up completing in the same cycle as a mask or open handle still sets
	// the flag, so an insertion is never lost; software clears it by masking
	logic extraction_flag;
	logic insertion_flag;
	logic insert_set;

	assign insert_set = (pwr_reg == hsg_pkg::HSG_PWR_SETTLE) && settle_done;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			extraction_flag <= 1'b0;
			insertion_flag  <= 1'b0;
		end else begin
			extraction_flag <= handle_sync_reg;
			if (insert_set) begin
				insertion_flag <= 1'b1;
			end else if (enum_mask_control || handle_sync_reg) begin
				insertion_flag <= 1'b0;
			end
		end
	end

	// board outputs: enum, indicator and slot reset
	logic enum_b_reg;
	logic led_safe_reg;
	logic slot_rst_b_reg;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			enum_b_reg     <= 1'b1;
			led_safe_reg   <= 1'b0;
			slot_rst_b_reg <= 1'b0;
		end else begin
			enum_b_reg     <= !((extraction_flag || insertion_flag) && !enum_mask_control);
			led_safe_reg   <= led_on_control;
			slot_rst_b_reg <= (pwr_reg == hsg_pkg::HSG_PWR_ON);
		end
	end

	assign enum_b     = enum_b_reg;
	assign led_safe   = led_safe_reg;
	assign slot_rst_b = slot_rst_b_reg;

	// ==========================================
	// pin sampling

	// board flags are wired to pins 2 and 3; pins 0 and 1 come from outside
	// pins 2 and 3 are sampled too but ignored: the board flags own those lines,
	// and software must keep their drivers off to avoid contention
	assign pin_level = {insertion_flag, extraction_flag, pin_sync_reg[1:0]};

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			pin_meta_reg <= `HSG_RST_NIBBLE;
			pin_sync_reg <= `HSG_RST_NIBBLE;
			in_reg       <= `HSG_RST_NIBBLE;
		end else begin
			pin_meta_reg <= 4'(gpio_in);
			pin_sync_reg <= pin_meta_reg;
			in_reg       <= pin_level;
		end
	end

	// ==========================================
	// read path

	// lanes not enabled read zero; the reserved nibble always reads zero
	always_comb begin
		rdata_next = `HSG_RST_WORD;
		if (!cfg_be_b[`HSG_LANE_OUT_DATA]) begin
			rdata_next[`HSG_OD_CLR_LSB +: 4] = od_clr_reg;
			rdata_next[`HSG_OD_SET_LSB +: 4] = od_set_reg;
		end
		if (!cfg_be_b[`HSG_LANE_OUT_EN]) begin
			rdata_next[`HSG_OE_CLR_LSB +: 4] = oe_clr_reg;
			rdata_next[`HSG_OE_SET_LSB +: 4] = oe_set_reg;
		end
		if (!cfg_be_b[`HSG_LANE_IN_DATA]) begin
			rdata_next[`HSG_IN_RSVD_LSB +: 4] = 4'h0;
			rdata_next[`HSG_IN_PIN_LSB +: 4]  = in_reg;
		end
	end

	// read answer registered one edge after the request
	// the data then stands until the next read hit, so a slow reader still finds it
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			rdata_reg  <= `HSG_RST_WORD;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= rd_hit;
			if (rd_hit) begin
				rdata_reg <= rdata_next;
			end
		end
	end

	assign cfg_rdata  = rdata_reg;
	assign cfg_rvalid = rvalid_reg;

endmodule : hsg_gpio_port

// [core/hsg_map.svh]
// register offsets, field positions, reset values and timing counts of the hotswap gpio port
`ifndef HSG_MAP_SVH
`define HSG_MAP_SVH

// ==========================================
// configuration space placement
`define HSG_DWORD_ADDR      8'h64
`define HSG_OFS_OUT_DATA    8'h65
`define HSG_OFS_OUT_EN      8'h66
`define HSG_OFS_IN_DATA     8'h67

// ==========================================
// byte lanes inside the doubleword
`define HSG_LANE_OUT_DATA   1
`define HSG_LANE_OUT_EN     2
`define HSG_LANE_IN_DATA    3

// ==========================================
// field positions (low bit of each nibble)
`define HSG_OD_CLR_LSB      8
`define HSG_OD_SET_LSB      12
`define HSG_OE_CLR_LSB      16
`define HSG_OE_SET_LSB      20
`define HSG_IN_RSVD_LSB     24
`define HSG_IN_PIN_LSB      28

// ==========================================
// reset values
`define HSG_RST_NIBBLE      4'h0
`define HSG_RST_WORD        32'h0000_0000

// ==========================================
// pin assignment of the hotswap bits
`define HSG_PIN_LED         0
`define HSG_PIN_MASK        1
`define HSG_PIN_EXTRACT     2
`define HSG_PIN_INSERT      3

// ==========================================
// timing: supply must be stable this long before slot reset is released
`define HSG_SETTLE_NS       1000
`define HSG_CLK_NS          10
`define HSG_SETTLE_CYC      ((`HSG_SETTLE_NS + `HSG_CLK_NS - 1) / `HSG_CLK_NS)

`endif

// [core/hsg_pkg.sv]
// types shared by the hotswap gpio port
package hsg_pkg;

	// ==========================================
	// back-end supply sequencing states
	typedef enum logic [1:0] {
		HSG_PWR_OFF,
		HSG_PWR_SETTLE,
		HSG_PWR_ON
	} hsg_pwr_t;

	typedef logic [3:0] hsg_nibble_t;

endpackage : hsg_pkg

// [tb/hsg_gpio_props.sv]
// assertion checker of the hotswap gpio port
`timescale 1ns/1ps

// ==========================================
// checker
module hsg_gpio_props #(
	parameter int PINS       = 4,
	parameter int SETTLE_CYC = 4
) (
	// clock and reset
	input wire logic            mclk,
	input wire logic            rst_b,
	// configuration access
	input wire logic            cfg_wr,
	input wire logic            cfg_rd,
	input wire logic [7:0]      cfg_addr,
	input wire logic [3:0]      cfg_be_b,
	input wire logic [31:0]     cfg_wdata,
	input wire logic [31:0]     cfg_rdata,
	input wire logic            cfg_rvalid,
	// pins and board
	input wire logic [PINS-1:0] gpio_out,
	input wire logic [PINS-1:0] gpio_oe,
	input wire logic            supply_good,
	input wire logic            enum_b,
	input wire logic            slot_rst_b
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	// request decode
	wire logic hit   = cfg_addr[7:2] == 6'h19;
	wire logic wr_od = cfg_wr && hit && !cfg_be_b[1];
	wire logic wr_oe = cfg_wr && hit && !cfg_be_b[2];

	// properties
	read_answer_a: assert property (cfg_rd && hit |=> cfg_rvalid)
		else $error("read not answered");
	quiet_input_a: assert property ((gpio_out & ~gpio_oe) == '0)
		else $error("input-only pin driven");
	oe_set_a: assert property ((wr_oe && cfg_wdata[19:16] == 4'h0 ##1 !cfg_wr) |-> ##1
		(gpio_oe & $past(cfg_wdata[23:20], 2)) == $past(cfg_wdata[23:20], 2)) else $error("enable set lost");
	oe_clr_a: assert property ((wr_oe && cfg_wdata[23:20] == 4'h0 ##1 !cfg_wr) |-> ##1
		(gpio_oe & $past(cfg_wdata[19:16], 2)) == '0) else $error("enable clear lost");
	od_set_a: assert property ((wr_od && cfg_wdata[11:8] == 4'h0 ##1 !cfg_wr) |-> ##1
		(gpio_out & $past(cfg_wdata[15:12], 2)) == (gpio_oe & $past(cfg_wdata[15:12], 2))) else $error("set lost");
	od_clr_a: assert property ((wr_od && cfg_wdata[15:12] == 4'h0 ##1 !cfg_wr) |-> ##1
		(gpio_out & $past(cfg_wdata[11:8], 2)) == '0) else $error("clear lost");
	rsvd_zero_a: assert property (cfg_rvalid |-> cfg_rdata[27:24] == 4'h0)
		else $error("reserved bits set");
	reset_clear_a: assert property (disable iff (1'b0) !rst_b |=> gpio_oe == '0 && enum_b && !slot_rst_b)
		else $error("reset state wrong");
	mask_hold_a: assert property ((gpio_oe[1] && gpio_out[1]) [*4] |-> enum_b)
		else $error("masked interrupt raised");
	slot_drop_a: assert property (!supply_good [*5] |-> !slot_rst_b)
		else $error("slot reset released");
	cover property (wr_oe && cfg_wdata[23:20] != 4'h0);
	cover property (!enum_b);
	cover property (slot_rst_b);
endmodule : hsg_gpio_props

bind hsg_gpio_port hsg_gpio_props #(.PINS(PINS), .SETTLE_CYC(SETTLE_CYC)) i_props (
	.mclk(mclk), .rst_b(rst_b), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be_b(cfg_be_b),
	.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .gpio_out(gpio_out),
	.gpio_oe(gpio_oe), .supply_good(supply_good), .enum_b(enum_b), .slot_rst_b(slot_rst_b));

// [tb/hsg_pin_model.sv]
// board side level model of the gpio pins
`timescale 1ns/1ps

// ==========================================
// pin wire
module hsg_pin_model (
	// bridge side
	input  wire logic [3:0] gpio_out,
	input  wire logic [3:0] gpio_oe,
	// board side
	input  wire logic [3:0] board_lvl,
	output logic      [3:0] gpio_in
);
	// enabled pins carry the bridge value, others the board level
	assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & board_lvl);
endmodule : hsg_pin_model

// [tb/hsg_gpio_port_tb.sv]
// self-checking testbench of the hotswap gpio port
`timescale 1ns/1ps

// ==========================================
// testbench
module hsg_gpio_port_tb;
	localparam int SC = 4;
	logic        mclk, rst_b, cfg_wr, cfg_rd, handle_open, supply_good;
	logic        cfg_rvalid, enum_b, led_safe, slot_rst_b;
	logic [7:0]  cfg_addr;
	logic [3:0]  cfg_be_b, board_lvl, gpio_in, gpio_out, gpio_oe;
	logic [31:0] cfg_wdata, cfg_rdata;
	logic [15:0] lfsr;
	int          err_count, tests_run, cyc, ods, odc, oes, oec, od, oe, insert_exp, extract_exp;

	hsg_gpio_port #(.PINS(4), .SETTLE_CYC(SC)) i_dut (.mclk(mclk), .rst_b(rst_b), .cfg_wr(cfg_wr),
		.cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be_b(cfg_be_b), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.cfg_rvalid(cfg_rvalid), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
		.handle_open(handle_open), .supply_good(supply_good), .enum_b(enum_b), .led_safe(led_safe),
		.slot_rst_b(slot_rst_b));
	hsg_pin_model i_pins (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .board_lvl(board_lvl), .gpio_in(gpio_in));

	// clock and hang guard
	initial begin
		mclk = 0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 4000) begin
			err_count++;
			give_verdict();
		end
	end

	// helpers
	function automatic logic [3:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr[3:0];
	endfunction : rnd
	function automatic logic [31:0] exp_word();
		int lvl;
		lvl = ((oe & od) | (~oe & int'(board_lvl))) & 3;
		return {4'(lvl | (extract_exp << 2) | (insert_exp << 3)), 4'h0, 4'(oes), 4'(oec), 4'(ods), 4'(odc), 8'h00};
	endfunction : exp_word
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : idle
	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		idle(1);
		{cfg_wr, cfg_addr, cfg_be_b, cfg_wdata} = {1'b1, a, be, d};
		idle(1);
		cfg_wr = 0;
		if (a[7:2] == 6'h19 && !be[1]) begin
			ods = d[15:12];
			odc = d[11:8];
			od = (od & ~odc) | ods;
		end
		if (a[7:2] == 6'h19 && !be[2]) begin
			oes = d[23:20];
			oec = d[19:16];
			oe = (oe & ~oec) | oes;
		end
		if ((oe & od & 2) != 0) insert_exp = 0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		idle(1);
		{cfg_rd, cfg_addr, cfg_be_b} = {1'b1, a, 4'b0001};
		idle(1);
		cfg_rd = 0;
		for (int i = 0; i < 3 && cfg_rvalid !== 1'b1; i++) idle(1);
		chk(cfg_rvalid, a == 8'h64);
		if (a == 8'h64) chk(cfg_rdata, exp_word());
	endtask : rd
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict

	// main sequence
	initial begin
		{rst_b, cfg_wr, cfg_rd, handle_open, supply_good, cfg_addr, cfg_be_b, cfg_wdata, board_lvl} = '0;
		lfsr = 16'h8b68;
		repeat (4) @(posedge mclk);
		#1;
		rst_b = 1;
		chk(gpio_oe, 0);
		rd(8'h64);
		$display("test reset done");
		repeat (16) begin
			board_lvl = rnd();
			wr(8'h64, 4'b1001 | (rnd() & 4'b0110), {8'h00, rnd() & 4'h3, rnd(), rnd(), rnd(), 8'h00});
			idle(1);
			chk(gpio_oe, oe);
			chk(gpio_out, od & oe);
			idle(3);
			rd(8'h64);
		end
		wr(8'h68, 4'b0000, 32'hffff_ffff);
		wr(8'h64, 4'b0111, 32'hffff_ffff);
		rd(8'h68);
		rd(8'h64);
		$display("test set and clear done");
		wr(8'h64, 4'b1001, 32'h000f_0f00);
		supply_good = 1;
		idle(SC + 12);
		insert_exp = 1;
		chk({slot_rst_b, enum_b}, 2'b10);
		rd(8'h64);
		wr(8'h64, 4'b1001, 32'h0030_3000);
		idle(6);
		chk({enum_b, led_safe}, 2'b11);
		handle_open = 1;
		extract_exp = 1;
		idle(6);
		chk(enum_b, 1);
		rd(8'h64);
		wr(8'h64, 4'b1101, 32'h0000_0200);
		idle(6);
		chk({enum_b, led_safe}, 2'b01);
		supply_good = 0;
		idle(8);
		chk(slot_rst_b, 0);
		$display("test hotswap done");
		give_verdict();
	end
endmodule : hsg_gpio_port_tb
